// ### hdl/gcsr_defs.vh
/*
  register offsets, field positions, reset values and timing counts of the
  general configuration and status bank.
  assumes inclusion by bare name from the bank's design files only.
*/
`ifndef GCSR_DEFS_VH
`define GCSR_DEFS_VH

// ----------------------------------------------------------------------------
// register addresses (7-bit register index)
// ----------------------------------------------------------------------------
`define GCSR_ADDR_GLOBAL_STATUS_FLAGS      7'h01
`define GCSR_ADDR_WRCNT      7'h02
`define GCSR_ADDR_REPLY      7'h03
`define GCSR_ADDR_FPROG      7'h04
`define GCSR_ADDR_FREAD      7'h05
`define GCSR_ADDR_PINS       7'h06
`define GCSR_ADDR_TRIM       7'h07
`define GCSR_WRITE_FLAG      8'h80

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define GCSR_ST_RESET        0
`define GCSR_ST_DRVERR       1
`define GCSR_ST_UVCP         2
`define GCSR_FP_BIT_LSB      0
`define GCSR_FP_BIT_MSB      2
`define GCSR_FP_BYTE_LSB     4
`define GCSR_FP_BYTE_MSB     5
`define GCSR_FP_KEY_LSB      8
`define GCSR_FP_KEY_MSB      15
`define GCSR_FP_KEY          8'hBD
`define GCSR_PIN_ENN         0
`define GCSR_PIN_SEL0        2
`define GCSR_PIN_SEL1        3
`define GCSR_PIN_DIAGNOSTIC_OUT_PIN        4
`define GCSR_PIN_PDN         6
`define GCSR_PIN_STEP        7
`define GCSR_PIN_CHOP        8
`define GCSR_PIN_DIR         9
`define GCSR_VER_LSB         24
`define GCSR_TRIM_OSC_MSB    4
`define GCSR_TRIM_OT_LSB     8
`define GCSR_TRIM_OT_MSB     9

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define GCSR_RST_ZERO        32'h0000_0000
`define GCSR_VERSION         8'h5A
`define GCSR_BIT_TIMES_UNIT  8
`define GCSR_CLK_HZ          10000000
`define GCSR_PROG_TIME_US    10000
`define GCSR_PROG_CYCLES     ((`GCSR_PROG_TIME_US * (`GCSR_CLK_HZ / 1000000)))

`endif

// ### hdl/gcsr_fuse_array.v
/*
  one-time-programmable fuse store: three bytes whose bits can only be set.
  assumes the bank above it gates programming with the unlock key.
*/
`timescale 1ns/1ns
`include "gcsr_defs.vh"

module gcsr_fuse_array
#(
  parameter PROG_CYCLES = `GCSR_PROG_CYCLES
)
(
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // programming request
  input  wire        prog_i,
  input  wire [1:0]  byte_sel_i,
  input  wire [2:0]  bit_sel_i,
  // contents
  output reg  [23:0] fuse_o,
  output reg         busy_o
);

  reg [31:0] cnt_q;
  reg [23:0] mask_q;

  // ----------------------------------------------------------------------------
  // burn process
  // ----------------------------------------------------------------------------
  // fuses survive reset on purpose; contents are set-only
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      busy_o <= 1'b0;
      cnt_q  <= 32'h0000_0000;
      mask_q <= 24'h00_0000;
    end
    else if (busy_o)
    begin
      if (cnt_q >= PROG_CYCLES - 1)
      begin
        busy_o <= 1'b0;
        fuse_o <= fuse_o | mask_q;   // [R9]
      end
      cnt_q <= cnt_q + 32'h0000_0001;
    end
    else if (prog_i && byte_sel_i != 2'h3)
    begin
      busy_o <= 1'b1;
      cnt_q  <= 32'h0000_0000;
      mask_q <= 24'h00_0001 << {byte_sel_i, bit_sel_i};  // [R10]
    end
  end

  // unprogrammed fuses read zero from power-up
  initial fuse_o = 24'h00_0000;

endmodule

// ### hdl/gcsr_regs.v
/*
  general configuration and status register bank of the driver.
  assumes a datagram engine on the same clock that delivers decoded accesses
  as one-cycle strobes with address, and raw pins synchronised here.
*/
// Operation
// [R1] reset sets status bit 0.
// [R2] status flags clear only by writing one to their bit.
// [R3] bit 1 latches driver shutdown; clear works only when errors are gone.
// [R4] bit 2 follows pump undervoltage live; stage disabled meanwhile.
// [R5] write counter increments per good write, wraps 255 to 0.
// [R6] reads never change the write counter.
// [R7] four-bit reply delay maps to 8 or odd multiples of 8 bit times.
// [R8] host avoids shortest reply delay on a shared line.
// [R9] fuse write sets one bit, selected by low three bits.
// [R10] bits 5 to 4 select fuse byte 0, 1 or 2.
// [R11] programming needs key 0xBD in bits 15 to 8.
// [R12] host waits 10 ms per fuse bit, then checks readback.
// [R13] reading programming register refreshes fuse readback.
// [R14] readback shows fuse bytes 0, 1, 2 low to high.
// [R15] input register reports live pins; unused bits zero.
// [R16] bits 31 to 24 hold fixed version code.
// [R17] five-bit oscillator trim, monotonic lowest to highest.
// [R18] oscillator trim loads from fuses at reset.
// [R19] write addresses carry 0x80, reads plain address.
// [R20] registers reset to zero unless fuse default given.
// [R21] unassigned bits read zero, writes ignored.
`timescale 1ns/1ns
`include "gcsr_defs.vh"

module gcsr_regs
#(
  parameter [7:0] VERSION     = `GCSR_VERSION,   // arbitrary value
  parameter       PROG_CYCLES = `GCSR_PROG_CYCLES
)
(
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // access from datagram engine
  input  wire        acc_valid_i,
  input  wire [7:0]  acc_addr_i,
  input  wire [31:0] acc_wdata_i,
  output reg  [31:0] acc_rdata_o,
  output reg         acc_rvalid_o,
  // driver status
  input  wire        drv_err_i,
  input  wire        pump_undervoltage_flag_i,
  // pins
  input  wire        enable_low_pin_i,
  input  wire        step_res_sel0_i,
  input  wire        step_res_sel1_i,
  input  wire        diagnostic_out_pin_i,
  input  wire        powerdown_serial_pin_i,
  input  wire        step_pin_i,
  input  wire        chopper_select_pin_i,
  input  wire        dir_pin_i,
  // configuration outputs
  output reg  [3:0]  reply_delay_o,
  output reg  [6:0]  reply_bits_o,
  output reg  [4:0]  osc_trim_o,
  output reg  [1:0]  thermal_limit_select_o,
  output reg         stage_enable_o,
  output reg         fuse_busy_o
);

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  wire [7:0] pins_raw = {dir_pin_i, chopper_select_pin_i, step_pin_i, powerdown_serial_pin_i,
                         diagnostic_out_pin_i, step_res_sel1_i, step_res_sel0_i, enable_low_pin_i};
  reg  [7:0] pins_m_q;
  reg  [7:0] pins_q;
  reg  [1:0] err_m_q;
  reg  [1:0] err_q;

  // two stages before any logic sees a pin
  always @(posedge clk_i)
  begin
    pins_m_q <= pins_raw;
    pins_q   <= pins_m_q;
    err_m_q  <= {pump_undervoltage_flag_i, drv_err_i};
    err_q    <= err_m_q;
  end

  // ----------------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------------
  wire       is_wr  = acc_valid_i & acc_addr_i[7];          // [R19]
  wire       is_rd  = acc_valid_i & ~acc_addr_i[7];
  wire [6:0] reg_a  = acc_addr_i[6:0];
  wire       key_ok = acc_wdata_i[`GCSR_FP_KEY_MSB:`GCSR_FP_KEY_LSB] == `GCSR_FP_KEY;
  wire       prog   = is_wr && reg_a == `GCSR_ADDR_FPROG && key_ok;  // [R11]

  reg  [1:0]  st_q;
  reg  [7:0]  wrcnt_q;
  reg         trim_load_q;
  reg         fresh_q;
  reg  [23:0] fread_q;
  wire [23:0] fuse_w;
  wire        busy_w;

  // ----------------------------------------------------------------------------
  // fuse array
  // ----------------------------------------------------------------------------
  gcsr_fuse_array #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_fuse (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .prog_i     (prog),
    .byte_sel_i (acc_wdata_i[`GCSR_FP_BYTE_MSB:`GCSR_FP_BYTE_LSB]),
    .bit_sel_i  (acc_wdata_i[`GCSR_FP_BIT_MSB:`GCSR_FP_BIT_LSB]),
    .fuse_o     (fuse_w),
    .busy_o     (busy_w)
  );

  // ----------------------------------------------------------------------------
  // status flags, counter, config
  // ----------------------------------------------------------------------------
  // set wins over clear; drv_err clear only once the error is gone
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_q        <= 2'h1;                                  // [R1]
      wrcnt_q     <= 8'h00;                                 // [R20]
      reply_delay_o <= 4'h0;
      trim_load_q <= 1'b1;
      fresh_q     <= 1'b0;
      fread_q     <= 24'h00_0000;
      osc_trim_o  <= 5'h00;
      thermal_limit_select_o <= 2'h0;
    end
    else
    begin
      st_q[0] <= st_q[0] & ~(is_wr && reg_a == `GCSR_ADDR_GLOBAL_STATUS_FLAGS && acc_wdata_i[`GCSR_ST_RESET]);  // [R2]
      st_q[1] <= err_q[0] | (st_q[1] &
                 ~(is_wr && reg_a == `GCSR_ADDR_GLOBAL_STATUS_FLAGS && acc_wdata_i[`GCSR_ST_DRVERR]));  // [R3]
      if (is_wr)
        wrcnt_q <= wrcnt_q + 8'h01;                         // [R5]
      if (is_wr && reg_a == `GCSR_ADDR_REPLY)
        reply_delay_o <= acc_wdata_i[3:0];                  // [R7]
      if (trim_load_q)
      begin
        // first cycle after release: trim from the low five bits of fuse byte 0
        trim_load_q <= 1'b0;
        osc_trim_o  <= fuse_w[4:0];                         // [R18]
        fread_q     <= fuse_w;
      end
      else if (is_wr && reg_a == `GCSR_ADDR_TRIM)
      begin
        osc_trim_o             <= acc_wdata_i[`GCSR_TRIM_OSC_MSB:0];  // [R17]
        thermal_limit_select_o <= acc_wdata_i[`GCSR_TRIM_OT_MSB:`GCSR_TRIM_OT_LSB];
      end
      if (prog)
        fresh_q <= 1'b1;
      // besides the load after reset, readback refreshes only on a read of the programming register
      if (is_rd && reg_a == `GCSR_ADDR_FPROG && fresh_q && !busy_w)
      begin
        fread_q <= fuse_w;                                  // [R13]
        fresh_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // derived outputs
  // ----------------------------------------------------------------------------
  // reply delay in units of 8 bit times: 1 for codes 0,1 else code|1
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      reply_bits_o   <= 7'h08;
      stage_enable_o <= 1'b0;
      fuse_busy_o    <= 1'b0;
    end
    else
    begin
      reply_bits_o   <= {3'h0, reply_delay_o | 4'h1} * 7'h08;  // [R7]
      stage_enable_o <= ~err_q[1] & ~err_q[0];                 // [R4]
      fuse_busy_o    <= busy_w;
    end
  end

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  reg [31:0] rd_d;

  // write-only and unmapped registers answer zero
  always @*
  begin
    rd_d = `GCSR_RST_ZERO;
    case (reg_a)
      `GCSR_ADDR_GLOBAL_STATUS_FLAGS: rd_d = {29'h0, err_q[1], st_q};       // [R4]
      `GCSR_ADDR_WRCNT: rd_d = {24'h0, wrcnt_q};              // [R6]
      `GCSR_ADDR_FREAD: rd_d = {8'h00, fread_q};              // [R14]
      `GCSR_ADDR_PINS:  rd_d = {VERSION, 14'h0, pins_q[7:6], pins_q[5:4], 1'b0,
                                 pins_q[3], pins_q[2:1], 1'b0, pins_q[0]};  // [R15] [R16]
      `GCSR_ADDR_TRIM:  rd_d = {22'h0, thermal_limit_select_o, 3'h0, osc_trim_o};  // [R21]
      default:          rd_d = `GCSR_RST_ZERO;
    endcase
  end

  // registered answer one cycle after the read strobe
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      acc_rdata_o  <= `GCSR_RST_ZERO;
      acc_rvalid_o <= 1'b0;
    end
    else
    begin
      acc_rvalid_o <= is_rd;
      if (is_rd)
        acc_rdata_o <= rd_d;
    end
  end

endmodule

// ### dv/gcsr_regs_properties.sv
/*
  port checker of the config and status bank.
  assumes it is bound into gcsr_regs, with one clock and a synchronous reset.
*/
`timescale 1ns/1ns
module gcsr_regs_properties
#(
  parameter [7:0] VERSION = 8'h5A  // arbitrary value
)
(
  // clock and reset
  input logic        clk_i,
  input logic        resetn_i,
  // access port
  input logic        acc_valid_i,
  input logic [7:0]  acc_addr_i,
  input logic [31:0] acc_wdata_i,
  input logic [31:0] acc_rdata_o,
  input logic        acc_rvalid_o,
  // status and configuration
  input logic        pump_undervoltage_flag_i,
  input logic [3:0]  reply_delay_o,
  input logic [6:0]  reply_bits_o,
  input logic [4:0]  osc_trim_o,
  input logic [1:0]  thermal_limit_select_o,
  input logic        stage_enable_o,
  input logic        fuse_busy_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // pump undervoltage crosses a two-stage synchroniser, hence the held windows
  read_answer_a: assert property (acc_valid_i && !acc_addr_i[7] |=> acc_rvalid_o)
    else $error("read not answered");
  stage_off_a: assert property (pump_undervoltage_flag_i [*4] |=> !stage_enable_o)
    else $error("stage enabled during undervoltage");
  uv_live_a: assert property (pump_undervoltage_flag_i [*5] ##0 acc_valid_i && acc_addr_i == 8'h01 |=> acc_rdata_o[2])
    else $error("undervoltage flag not live");
  reply_bits_a: assert property (1'b1 |=> reply_bits_o == ((({3'h0, $past(reply_delay_o)} & 7'h0E) << 3) | 7'h08))
    else $error("reply bit times wrong");
  reply_wr_a: assert property (acc_valid_i && acc_addr_i == 8'h83 |=> {28'h0, reply_delay_o} == ($past(acc_wdata_i) & 32'hF))
    else $error("reply delay not written");
  trim_wr_a: assert property (acc_valid_i && acc_addr_i == 8'h87 |=>
    {22'h0, thermal_limit_select_o, 3'h0, osc_trim_o} == ($past(acc_wdata_i) & 32'h31F)) else $error("trim not written");
  pin_fields_a: assert property (acc_valid_i && acc_addr_i == 8'h06 |=>
    acc_rdata_o[31:24] == VERSION && (acc_rdata_o & 32'h00FF_FC22) == 32'h0) else $error("pin register fields wrong");
  cnt_read_a: assert property (acc_valid_i && acc_addr_i == 8'h02 ##1 (!acc_valid_i) [*2] ##1
    acc_valid_i && acc_addr_i == 8'h02 |=> acc_rdata_o == $past(acc_rdata_o)) else $error("read changed counter");
  bad_key_a: assert property (acc_valid_i && acc_addr_i == 8'h84 && acc_wdata_i[15:8] != 8'hBD |=>
    !$rose(fuse_busy_o) ##1 !$rose(fuse_busy_o)) else $error("burn without key");
  burn_start_a: assert property (acc_valid_i && acc_addr_i == 8'h84 && acc_wdata_i[15:8] == 8'hBD &&
    acc_wdata_i[5:4] != 2'h3 && !fuse_busy_o |-> ##[1:3] fuse_busy_o) else $error("burn not started");
  cover property (acc_valid_i && acc_addr_i == 8'h01);
  cover property ($rose(fuse_busy_o));
  cover property (acc_valid_i && acc_addr_i == 8'h87);
endmodule

// ### dv/gcsr_host_model.sv
/*
  host side of the access port: one register access at a time.
  assumes the bank answers a read one cycle after taking it.
*/
`timescale 1ns/1ns
module gcsr_host_model
(
  // clock
  input  wire        clk_i,
  // access port
  output reg         acc_valid_o,
  output reg  [7:0]  acc_addr_o,
  output reg  [31:0] acc_wdata_o,
  input  wire [31:0] acc_rdata_i,
  input  wire        acc_rvalid_i
);
  // ----------------------------------------
  // access task
  // ----------------------------------------
  initial
  begin
    acc_valid_o = 1'b0;
    acc_addr_o  = 8'h00;
    acc_wdata_o = 32'h0;
  end
  // the released bus shows the inverse, so a stale value is never mistaken
  task automatic xfer(input w, input [6:0] a, input [31:0] d, output [31:0] q);
  begin
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o  <= {w, a};
    acc_wdata_o <= d;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    acc_addr_o  <= ~{w, a};
    acc_wdata_o <= ~d;
    @(posedge clk_i);
    q = (acc_rvalid_i === 1'b1) ? acc_rdata_i : 32'hXXXX_XXXX;
  end
  endtask
endmodule

// ### dv/tb.sv
/*
  self-checking bench of the config and status bank.
  assumes the host model drives the access port and a short burn time.
*/
`timescale 1ns/1ns
module tb;
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  localparam       PROG    = 4;
  localparam [7:0] VERSION = 8'h5A;  // arbitrary value
  reg         clk_i, resetn_i, drv_err, pump_undervoltage_flag;
  reg  [7:0]  pins;
  wire        acc_valid, acc_rvalid, stage;
  wire [7:0]  acc_addr;
  wire [31:0] acc_wdata, acc_rdata;
  wire [6:0]  bits;
  integer     err_count, tests_run, cyc, i, n, b;
  reg  [31:0] q, d, fuse;
  gcsr_regs #(.VERSION(VERSION), .PROG_CYCLES(PROG)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .acc_valid_i(acc_valid), .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata), .acc_rdata_o(acc_rdata),
    .acc_rvalid_o(acc_rvalid), .drv_err_i(drv_err), .pump_undervoltage_flag_i(pump_undervoltage_flag), .enable_low_pin_i(pins[0]),
    .step_res_sel0_i(pins[1]), .step_res_sel1_i(pins[2]), .diagnostic_out_pin_i(pins[3]),
    .powerdown_serial_pin_i(pins[4]), .step_pin_i(pins[5]), .chopper_select_pin_i(pins[6]), .dir_pin_i(pins[7]),
    .reply_delay_o(), .reply_bits_o(bits), .osc_trim_o(), .thermal_limit_select_o(), .stage_enable_o(stage),
    .fuse_busy_o());
  gcsr_host_model i_host (.clk_i(clk_i), .acc_valid_o(acc_valid), .acc_addr_o(acc_addr),
    .acc_wdata_o(acc_wdata), .acc_rdata_i(acc_rdata), .acc_rvalid_i(acc_rvalid));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] pin_exp(input [7:0] p);
    pin_exp = {VERSION, 14'h0, p[7:4], 1'b0, p[3:1], 1'b0, p[0]};
  endfunction
  task automatic chk(input string name, input [31:0] exp, input [31:0] got);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %0s exp %h got %h", name, exp, got);
    end
  end
  endtask
  task automatic rdc(input [6:0] a, input [31:0] exp);
  begin
    i_host.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg%0h", a), exp, q);
  end
  endtask
  task automatic wr(input [6:0] a, input [31:0] v);
    i_host.xfer(1'b1, a, v, q);
  endtask
  task automatic stop_test;
  begin
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0; tests_run = 0; cyc = 0; fuse = 32'h0;
    resetn_i = 1'b0; drv_err = 1'b0; pump_undervoltage_flag = 1'b0; pins = 8'h00;
    void'($urandom(32'h4B3E));
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rdc(7'h01, 32'h1);
    rdc(7'h02, 32'h0);
    rdc(7'h07, 32'h0);
    wr(7'h01, 32'hFFFF_FFFE);
    rdc(7'h01, 32'h1);
    wr(7'h01, 32'h1);
    rdc(7'h01, 32'h0);
    drv_err <= 1'b1;
    repeat (5) @(posedge clk_i);
    wr(7'h01, 32'h2);
    rdc(7'h01, 32'h2);
    drv_err <= 1'b0;
    repeat (5) @(posedge clk_i);
    rdc(7'h01, 32'h2);
    wr(7'h01, 32'h2);
    rdc(7'h01, 32'h0);
    pump_undervoltage_flag <= 1'b1;
    repeat (5) @(posedge clk_i);
    rdc(7'h01, 32'h4);
    chk("stage", 32'h0, {31'h0, stage});
    pump_undervoltage_flag <= 1'b0;
    repeat (5) @(posedge clk_i);
    rdc(7'h01, 32'h0);
    chk("stage", 32'h1, {31'h0, stage});
    rdc(7'h02, 32'h4);
    rdc(7'h02, 32'h4);
    // a single device sits on the line, so the shortest delays are allowed
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(7'h03, i);
      @(posedge clk_i);
      chk("bits", (i | 1) * 8, {25'h0, bits});
    end
    rdc(7'h03, 32'h0);
    // random writes avoid the fuse register and push the counter past its wrap
    for (i = 0; i < 250; i = i + 1)
    begin
      n = $urandom % 6;
      wr((n < 3) ? n + 1 : n + 2, $urandom);
    end
    rdc(7'h02, 32'hE);
    d = $urandom;
    wr(7'h07, d);
    rdc(7'h07, d & 32'h31F);
    for (i = 0; i < 4; i = i + 1)
    begin
      pins <= $urandom;
      repeat (4) @(posedge clk_i);
      rdc(7'h06, pin_exp(pins));
    end
    wr(7'h04, 32'h0000_0013);
    wr(7'h04, 32'h0000_BD33);
    repeat (PROG + 6) @(posedge clk_i);
    rdc(7'h04, 32'h0);
    rdc(7'h05, fuse);
    for (b = 0; b < 3; b = b + 1)
    begin
      n = (b == 0) ? $urandom % 5 : $urandom % 8;
      wr(7'h04, {16'h0, 8'hBD, 2'h0, b[1:0], 1'b0, n[2:0]});
      repeat (PROG + 6) @(posedge clk_i);
      // burn is done, but readback must hold until the programming register is read
      rdc(7'h05, fuse);
      fuse[8 * b + n] = 1'b1;
      rdc(7'h04, 32'h0);
      rdc(7'h05, fuse);
    end
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rdc(7'h01, 32'h1);
    i_host.xfer(1'b0, 7'h07, 32'h0, q);
    chk("trim", fuse & 32'h1F, q & 32'h1F);
    rdc(7'h05, fuse);
    stop_test;
  end
endmodule
bind gcsr_regs gcsr_regs_properties #(.VERSION(VERSION)) i_props (.*);
